// *** rtl/tdxc_pkg.sv ***
// constants and types for the de-alias and internal crosstalk config bank
package tdxc_pkg;
  localparam int unsigned TDXC_AW = 8;
  localparam int unsigned TDXC_DW = 24;
  // register offsets
  localparam logic [7:0] TDXC_OFS_XTALK_I = 8'h3d;
  localparam logic [7:0] TDXC_OFS_XTALK_Q = 8'h3e;
  localparam logic [7:0] TDXC_OFS_CALIB_T = 8'h3f;
  localparam logic [7:0] TDXC_OFS_DEALIAS = 8'h40;
  // reset values
  localparam logic [23:0] TDXC_RST_XTALK_I = 24'h000000;
  localparam logic [23:0] TDXC_RST_XTALK_Q = 24'h000000;
  localparam logic [23:0] TDXC_RST_CALIB_T = 24'h000000;
  localparam logic [23:0] TDXC_RST_DEALIAS = 24'h2021e0;
  // field positions
  localparam int unsigned TDXC_XTALK_W = 16;
  localparam int unsigned TDXC_TEMP_W = 12;
  localparam int unsigned TDXC_EXT_TEMP_LSB = 12;
  localparam int unsigned TDXC_ONCHIP_TEMP_LSB = 0;
  localparam int unsigned TDXC_RSVD_TOP_BIT = 23;
  localparam int unsigned TDXC_DUAL_BIT = 22;
  localparam int unsigned TDXC_SECOND_SEL_BIT = 21;
  localparam int unsigned TDXC_BETA_LSB = 15;
  localparam int unsigned TDXC_ALPHA_LSB = 9;
  localparam int unsigned TDXC_SCALE_W = 6;
  localparam int unsigned TDXC_RSVD_MID_LSB = 1;
  localparam int unsigned TDXC_RSVD_MID_W = 8;
  localparam int unsigned TDXC_ENABLE_BIT = 0;
  localparam logic [7:0] TDXC_RSVD_MID_PATTERN = 8'hf0;
  localparam logic [5:0] TDXC_SCALE_UNITY = 6'h10;
  localparam logic [5:0] TDXC_SCALE_DIV = 6'h10;

  // modulation plan seen by the phase datapath
  typedef enum logic [1:0] {
    TDXC_MOD_SINGLE_10M,
    TDXC_MOD_DUAL_6_7,
    TDXC_MOD_DUAL_6_5
  } tdxc_mod_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [23:0] wdata;
  } tdxc_req_t;

  typedef struct packed {
    logic [15:0] internal_xtalk_i_value;
    logic [15:0] internal_xtalk_q_value;
    logic [11:0] ext_sensor_calib_temp_ch2_low;
    logic [11:0] onchip_sensor_calib_temp_ch2_low;
    logic dealias_enable;
    logic dual_frequency_phase_enable;
    logic second_frequency_select;
    logic [5:0] dealias_beta_scale;
    logic [5:0] dealias_alpha_scale;
  } tdxc_cfg_t;
endpackage

// *** rtl/tdxc_config_regs.sv ***
// de-alias and internal crosstalk configuration register bank
// Summary of operation
// - in-phase internal crosstalk, 16 writable low bits, upper 8 read zero
// - quadrature internal crosstalk, 16 writable low bits, upper 8 read zero
// - external sensor calibration temperature, 12 bits at 23:12
// - on-chip sensor calibration temperature, 12 bits at 11:0
// - dual-frequency phase reported only when dual bit and de-alias enable set
// - dual bit 0 gives 10 MHz only; 1 adds selected second frequency
// - second-frequency select: 0 is 6/7 ratio, 1 is 6/5; resets to 1
// - beta scale 6 bits at 20:15, factor value/16, resets to zero
// - alpha scale 6 bits at 14:9, factor value/16, resets to 10h
// - de-alias enable: 0 single-measurement mode, 1 de-alias mode; resets 0
module tdxc_config_regs (
  input wire logic core_clk,
  input wire logic reset,
  input wire tdxc_pkg::tdxc_req_t req,
  output tdxc_pkg::tdxc_cfg_t cfg,
  output logic [23:0] rd_data,
  output logic rd_valid,
  output logic dual_phase_report,
  output tdxc_pkg::tdxc_mod_t mod_plan
);
  import tdxc_pkg::*;

  logic [15:0] xtalk_i_r;
  logic [15:0] xtalk_q_r;
  logic [23:0] calib_t_r;
  logic [23:0] dealias_r;
  logic [23:0] rd_data_r;
  logic rd_valid_r;
  logic dual_phase_report_r;
  tdxc_mod_t mod_plan_r;

  function automatic logic hit(input tdxc_req_t r, input logic [7:0] ofs);
    return r.wr && (r.addr == ofs);
  endfunction

  wire logic wr_i = hit(req, TDXC_OFS_XTALK_I);
  wire logic wr_q = hit(req, TDXC_OFS_XTALK_Q);
  wire logic wr_t = hit(req, TDXC_OFS_CALIB_T);
  wire logic wr_d = hit(req, TDXC_OFS_DEALIAS);

  // read mux; unmapped offsets read zero
  wire logic [23:0] rd_mux =
    (req.addr == TDXC_OFS_XTALK_I) ? {8'h00, xtalk_i_r} :
    (req.addr == TDXC_OFS_XTALK_Q) ? {8'h00, xtalk_q_r} :
    (req.addr == TDXC_OFS_CALIB_T) ? calib_t_r :
    (req.addr == TDXC_OFS_DEALIAS) ? dealias_r : 24'h000000;

  wire logic en_bit = dealias_r[TDXC_ENABLE_BIT];
  wire logic dual_bit = dealias_r[TDXC_DUAL_BIT];
  wire logic sel_bit = dealias_r[TDXC_SECOND_SEL_BIT];
  wire tdxc_mod_t mod_nxt = !dual_bit ? TDXC_MOD_SINGLE_10M :
                            (sel_bit ? TDXC_MOD_DUAL_6_5 : TDXC_MOD_DUAL_6_7);

  // storage; reserved fields of the control word are stored as written
  always_ff @(posedge core_clk) begin
    if (reset) begin
      xtalk_i_r <= TDXC_RST_XTALK_I[15:0];
      xtalk_q_r <= TDXC_RST_XTALK_Q[15:0];
      calib_t_r <= TDXC_RST_CALIB_T;
      dealias_r <= TDXC_RST_DEALIAS;
    end else begin
      if (wr_i) xtalk_i_r <= req.wdata[15:0];
      if (wr_q) xtalk_q_r <= req.wdata[15:0];
      if (wr_t) calib_t_r <= req.wdata;
      if (wr_d) dealias_r <= req.wdata;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      rd_data_r <= 24'h000000;
      rd_valid_r <= 1'b0;
      dual_phase_report_r <= 1'b0;
      mod_plan_r <= TDXC_MOD_SINGLE_10M;
    end else begin
      rd_valid_r <= req.rd;
      if (req.rd) rd_data_r <= rd_mux;
      dual_phase_report_r <= dual_bit && en_bit;
      mod_plan_r <= mod_nxt;
    end
  end

  assign cfg.internal_xtalk_i_value = xtalk_i_r;
  assign cfg.internal_xtalk_q_value = xtalk_q_r;
  assign cfg.ext_sensor_calib_temp_ch2_low =
    calib_t_r[TDXC_EXT_TEMP_LSB +: TDXC_TEMP_W];
  assign cfg.onchip_sensor_calib_temp_ch2_low =
    calib_t_r[TDXC_ONCHIP_TEMP_LSB +: TDXC_TEMP_W];
  assign cfg.dealias_enable = en_bit;
  assign cfg.dual_frequency_phase_enable = dual_bit;
  assign cfg.second_frequency_select = sel_bit;
  assign cfg.dealias_beta_scale = dealias_r[TDXC_BETA_LSB +: TDXC_SCALE_W];
  assign cfg.dealias_alpha_scale = dealias_r[TDXC_ALPHA_LSB +: TDXC_SCALE_W];
  assign rd_data = rd_data_r;
  assign rd_valid = rd_valid_r;
  assign dual_phase_report = dual_phase_report_r;
  assign mod_plan = mod_plan_r;

  // checks
  xtalk_i_top_a: assert property (@(posedge core_clk) disable iff (reset)
    req.rd && req.addr == TDXC_OFS_XTALK_I |=> rd_data[23:16] == 8'h00)
    else $error("in-phase upper bits not zero");
  xtalk_q_hold_a: assert property (@(posedge core_clk) disable iff (reset)
    wr_q |=> cfg.internal_xtalk_q_value == $past(req.wdata[15:0]))
    else $error("quadrature value not stored");
  ext_temp_a: assert property (@(posedge core_clk) disable iff (reset)
    wr_t |=> cfg.ext_sensor_calib_temp_ch2_low == $past(req.wdata[23:12]))
    else $error("external temperature field wrong");
  onchip_temp_a: assert property (@(posedge core_clk) disable iff (reset)
    wr_t |=> cfg.onchip_sensor_calib_temp_ch2_low == $past(req.wdata[11:0]))
    else $error("on-chip temperature field wrong");
  dual_report_a: assert property (@(posedge core_clk) disable iff (reset)
    dual_phase_report == $past(cfg.dual_frequency_phase_enable && cfg.dealias_enable))
    else $error("dual report does not follow enables");
  single_mode_a: assert property (@(posedge core_clk) disable iff (reset)
    !cfg.dual_frequency_phase_enable ##1 !cfg.dual_frequency_phase_enable
      |-> mod_plan == TDXC_MOD_SINGLE_10M)
    else $error("single frequency plan expected");
  second_sel_a: assert property (@(posedge core_clk)
    reset |=> cfg.second_frequency_select && cfg.dealias_beta_scale == 6'h00)
    else $error("select or beta reset value wrong");
  alpha_rst_a: assert property (@(posedge core_clk)
    reset |=> cfg.dealias_alpha_scale == TDXC_SCALE_UNITY && !cfg.dealias_enable)
    else $error("alpha or enable reset value wrong");
  beta_field_a: assert property (@(posedge core_clk) disable iff (reset)
    wr_d |=> cfg.dealias_beta_scale == $past(req.wdata[20:15]))
    else $error("beta field wrong");
  hold_value_a: assert property (@(posedge core_clk) disable iff (reset)
    !wr_i |=> $stable(cfg.internal_xtalk_i_value))
    else $error("in-phase value changed without write");
  read_back_a: assert property (@(posedge core_clk) disable iff (reset)
    wr_d ##1 !wr_d ##1 (req.rd && !req.wr && req.addr == TDXC_OFS_DEALIAS)
      |=> rd_data == $past(req.wdata, 3))
    else $error("control readback mismatch");
  mode_en_a: assert property (@(posedge core_clk) disable iff (reset)
    wr_d |=> cfg.dealias_enable == $past(req.wdata[0]))
    else $error("enable bit not stored");

  // write, hold, reset and upper-byte read checks of the crosstalk and temperature words
  xtalk_i_store_a: assert property (@(posedge core_clk) disable iff (reset)
    wr_i
      |=> cfg.internal_xtalk_i_value == $past(req.wdata[15:0]))
    else $error("in-phase value not stored");
  xtalk_q_top_a: assert property (@(posedge core_clk) disable iff (reset)
    req.rd && req.addr == TDXC_OFS_XTALK_Q
      |=> rd_data[23:16] == 8'h00)
    else $error("quadrature upper bits not zero");
  calib_rst_a: assert property (@(posedge core_clk)
    reset
      |=> cfg.ext_sensor_calib_temp_ch2_low == 12'h000 && cfg.internal_xtalk_i_value == 16'h0000)
    else $error("temperature or crosstalk reset value wrong");
  q_hold_a: assert property (@(posedge core_clk) disable iff (reset)
    !wr_q
      |=> $stable(cfg.internal_xtalk_q_value))
    else $error("quadrature value changed without write");
  ext_hold_a: assert property (@(posedge core_clk) disable iff (reset)
    !wr_t
      |=> $stable(cfg.ext_sensor_calib_temp_ch2_low))
    else $error("external temperature changed without write");
  onchip_hold_a: assert property (@(posedge core_clk) disable iff (reset)
    !wr_t
      |=> $stable(cfg.onchip_sensor_calib_temp_ch2_low))
    else $error("on-chip temperature changed without write");

  // control word fields and the derived frequency plan
  alpha_field_a: assert property (@(posedge core_clk) disable iff (reset)
    wr_d
      |=> cfg.dealias_alpha_scale == $past(req.wdata[14:9]))
    else $error("alpha field wrong");
  rsvd_reset_a: assert property (@(posedge core_clk)
    reset
      |=> dealias_r[TDXC_RSVD_MID_LSB +: TDXC_RSVD_MID_W] == TDXC_RSVD_MID_PATTERN)
    else $error("reserved pattern reset value wrong");
  ctrl_hold_a: assert property (@(posedge core_clk) disable iff (reset)
    !wr_d
      |=> $stable(cfg.dealias_enable))
    else $error("enable bit changed without write");
  beta_hold_a: assert property (@(posedge core_clk) disable iff (reset)
    !wr_d
      |=> $stable(cfg.dealias_beta_scale))
    else $error("beta field changed without write");
  alpha_hold_a: assert property (@(posedge core_clk) disable iff (reset)
    !wr_d
      |=> $stable(cfg.dealias_alpha_scale))
    else $error("alpha field changed without write");
  dual_plan_a: assert property (@(posedge core_clk) disable iff (reset)
    cfg.dual_frequency_phase_enable
      |=> mod_plan != TDXC_MOD_SINGLE_10M)
    else $error("dual frequency plan expected");
  plan_65_a: assert property (@(posedge core_clk) disable iff (reset)
    cfg.dual_frequency_phase_enable && cfg.second_frequency_select
      |=> mod_plan == TDXC_MOD_DUAL_6_5)
    else $error("six fifths plan expected");
  plan_67_a: assert property (@(posedge core_clk) disable iff (reset)
    cfg.dual_frequency_phase_enable && !cfg.second_frequency_select
      |=> mod_plan == TDXC_MOD_DUAL_6_7)
    else $error("six sevenths plan expected");

  // read port timing
  rd_pulse_a: assert property (@(posedge core_clk) disable iff (reset)
    req.rd
      |=> rd_valid)
    else $error("read valid missing");
  rd_idle_a: assert property (@(posedge core_clk) disable iff (reset)
    !req.rd
      |=> !rd_valid && $stable(rd_data))
    else $error("read port moved without read");
  unmapped_rd_a: assert property (@(posedge core_clk) disable iff (reset)
    req.rd && (req.addr < TDXC_OFS_XTALK_I || req.addr > TDXC_OFS_DEALIAS)
      |=> rd_data == 24'h000000)
    else $error("unmapped read not zero");

  dealias_on_c: cover property (@(posedge core_clk) disable iff (reset)
    dual_phase_report && mod_plan == TDXC_MOD_DUAL_6_7);
  dual_65_c: cover property (@(posedge core_clk) disable iff (reset)
    mod_plan == TDXC_MOD_DUAL_6_5);
  rd_after_wr_c: cover property (@(posedge core_clk) disable iff (reset)
    wr_i ##2 req.rd && req.addr == TDXC_OFS_XTALK_I);
  single_rd_c: cover property (@(posedge core_clk) disable iff (reset)
    rd_valid && mod_plan == TDXC_MOD_SINGLE_10M);
  unmapped_rd_c: cover property (@(posedge core_clk) disable iff (reset)
    req.rd && req.addr > TDXC_OFS_DEALIAS);
endmodule // tdxc_config_regs

// *** verification/tdxc_host.sv ***
// host model issuing single register accesses
module tdxc_host (
  input wire logic core_clk,
  output tdxc_pkg::tdxc_req_t req
);
  timeunit 1ns;
  timeprecision 1ps;
  import tdxc_pkg::*;
  initial req = '0;
  task automatic xfer(input logic w, input logic [7:0] a, input logic [23:0] d,
                      output logic [23:0] sent);
    sent = (a == TDXC_OFS_DEALIAS) ? {1'b0, d[22:9], TDXC_RSVD_MID_PATTERN, d[0]} : d;
    @(posedge core_clk);
    req <= '{wr: w, rd: !w, addr: a, wdata: sent};
    @(posedge core_clk);
    req <= '0;
  endtask
endmodule // tdxc_host

// *** verification/tdxc_config_regs_bench.sv ***
// self-checking bench for the de-alias and crosstalk config bank
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin n_mismatch++; \
  $display("BAD %s exp %h got %h", n, e, s); end end
module tdxc_config_regs_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import tdxc_pkg::*;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  tdxc_req_t req;
  tdxc_cfg_t cfg;
  logic [23:0] rd_data;
  logic rd_valid;
  logic dual_phase_report;
  tdxc_mod_t mod_plan;
  logic [23:0] exp_r [4];
  logic [31:0] seed = 32'hb518;
  logic [31:0] rnd;
  int n_mismatch = 0;
  int samples_checked = 0;
  int cyc = 0;
  tdxc_config_regs i_dut (.core_clk(core_clk), .reset(reset), .req(req), .cfg(cfg),
    .rd_data(rd_data), .rd_valid(rd_valid), .dual_phase_report(dual_phase_report),
    .mod_plan(mod_plan));
  tdxc_host i_host (.core_clk(core_clk), .req(req));
  initial forever #4 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc++;
    if (cyc > 5000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic tdxc_mod_t plan(input logic [23:0] c);
    return !c[22] ? TDXC_MOD_SINGLE_10M : (c[21] ? TDXC_MOD_DUAL_6_5 : TDXC_MOD_DUAL_6_7);
  endfunction
  task automatic tally_and_finish();
    if (n_mismatch == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic rst_exp();
    exp_r = '{24'h0, 24'h0, 24'h0, 24'h2021e0};
  endtask
  task automatic op(input logic w, input logic [7:0] a, input logic [23:0] d);
    logic hit;
    logic [23:0] s;
    logic [23:0] e;
    hit = a inside {[8'h3d:8'h40]};
    i_host.xfer(w, a, d, s);
    // upper byte of the crosstalk words is read-only zero
    if (w && hit) exp_r[2'(a - 8'h3d)] = s & ((a < 8'h3f) ? 24'h00ffff : 24'hffffff);
    #1;
    if (w) `CHK("rd_valid", 1'b0, rd_valid)
    if (!w) begin
      e = hit ? exp_r[2'(a - 8'h3d)] : 24'h0;
      `CHK("rd_valid", 1'b1, rd_valid)
      `CHK("rd_data", e, rd_data)
      `CHK("cfg", {exp_r[0][15:0], exp_r[1][15:0], exp_r[2], exp_r[3][0], exp_r[3][22:9]}, cfg)
      `CHK("dual", exp_r[3][22] & exp_r[3][0], dual_phase_report)
      `CHK("plan", plan(exp_r[3]), mod_plan)
    end
  endtask
  initial begin
    rst_exp();
    repeat (16) @(posedge core_clk);
    reset <= 1'b0;
    for (int a = 8'h3c; a <= 8'h41; a++) op(1'b0, 8'(a), 24'h0);
    for (int a = 8'h3c; a <= 8'h41; a++) op(1'b1, 8'(a), 24'hffffff);
    for (int a = 8'h3c; a <= 8'h41; a++) op(1'b0, 8'(a), 24'h0);
    for (int k = 0; k < 8; k++) begin
      op(1'b1, 8'h40, {1'b0, 2'(k), 20'h0, k[2]});
      op(1'b0, 8'h40, 24'h0);
    end
    for (int i = 0; i < 150; i++) begin
      seed = lfsr(seed);
      rnd = lfsr(seed ^ 32'h5a5a);
      op(seed[0], 8'h3c + 8'(seed[4:1] % 6), rnd[23:0]);
    end
    @(posedge core_clk);
    reset <= 1'b1;
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    rst_exp();
    for (int a = 8'h3d; a <= 8'h40; a++) op(1'b0, 8'(a), 24'h0);
    tally_and_finish();
  end
endmodule // tdxc_config_regs_bench
